// [rtl/pmd_clkdiv.sv]
/*
  pmd_clkdiv: square wave divider with a rising edge strobe.
  Assumes a half period of at least one system cycle.
*/
`timescale 1ns/1ps
module pmd_clkdiv #(
  parameter int unsigned W = 8
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // control
  input  wire logic [W-1:0] i_half,
  // outputs
  output logic              o_clk,
  output logic              o_rise
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         lvl;
    logic         rise;
  } pmd_div_s;

  pmd_div_s s_q;
  pmd_div_s s_d;

  always_comb begin
    s_d      = s_q;
    s_d.rise = 1'b0;
    if (s_q.cnt + 1'b1 >= i_half) begin
      s_d.cnt  = '0;
      s_d.lvl  = ~s_q.lvl;
      s_d.rise = ~s_q.lvl;
    end else begin
      s_d.cnt = W'(s_q.cnt + 1'b1);
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_clk  = s_q.lvl;
  assign o_rise = s_q.rise;
endmodule

// [rtl/pmd_if.sv]
/*
  pmd_if: MAC data interface wires between transceiver and MAC.
  Assumes both ends on one system clock; link clocks are sampled data.
*/
`timescale 1ns/1ps
interface pmd_if;
  logic       tx_clk;
  logic       rx_clk;
  logic       ref_clk;
  logic       tx_en;
  logic [3:0] txd;
  logic [3:0] rxd;
  logic       rx_dv;
  logic       rx_er;
  logic       crs;
  logic       col;

  modport phy (output tx_clk, output rx_clk, output ref_clk, input tx_en, input txd,
               output rxd, output rx_dv, output rx_er, output crs, output col);
  modport mac (input tx_clk, input rx_clk, input ref_clk, output tx_en, output txd,
               input rxd, input rx_dv, input rx_er, input crs, input col);
endinterface

// [rtl/pmd_mac.sv]
/*
  pmd_mac: MAC end of the MAC data interface. Launches transmit units on
  the rising edge of the clock it sees and collects received units.
  Assumes the form input matches the transceiver strap.
*/
`timescale 1ns/1ps
module pmd_mac
  import pmd_pkg::*;
(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // configuration
  input  wire logic [1:0] i_form,
  // user transmit
  input  wire logic       i_tx_valid,
  input  wire logic [3:0] i_tx_data,
  output logic            o_tx_ready,
  // user receive
  output logic            o_rx_valid,
  output logic [3:0]      o_rx_data,
  output logic            o_rx_err,
  output logic            o_col,
  // link
  pmd_if.mac              lnk
);
  typedef struct packed {
    logic [2:0] tck;
    logic [2:0] rck;
    logic       tx_en;
    logic [3:0] txd;
    logic       rdy;
    logic       rv;
    logic [3:0] rd;
    logic       re;
    logic       col;
  } pmd_mac_s;

  pmd_mac_s s_q;
  pmd_mac_s s_d;
  logic     trise;
  logic     rrise;

  always_comb begin
    s_d     = s_q;
    s_d.tck = {s_q.tck[1:0], (i_form == FORM_RED) ? lnk.ref_clk : lnk.tx_clk};
    s_d.rck = {s_q.rck[1:0], (i_form == FORM_RED) ? lnk.ref_clk : lnk.rx_clk};
    trise   = s_q.tck[1] & ~s_q.tck[2];
    rrise   = s_q.rck[1] & ~s_q.rck[2];
    s_d.rdy = 1'b0;
    s_d.rv  = 1'b0;
    if (trise) begin
      s_d.tx_en = i_tx_valid;
      s_d.txd   = i_tx_valid ? i_tx_data : 4'h0;
      s_d.rdy   = i_tx_valid;
    end
    if (rrise) begin
      s_d.rd = lnk.rxd;
      s_d.re = lnk.rx_er;
      case (i_form)
        FORM_RED: begin
          s_d.rv  = lnk.crs;
          s_d.col = lnk.crs & s_q.tx_en;
        end
        FORM_SERIAL: begin
          s_d.rv  = lnk.crs;
          s_d.col = lnk.col;
        end
        default: begin
          s_d.rv  = lnk.rx_dv;
          s_d.col = lnk.col;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign lnk.tx_en  = s_q.tx_en;
  assign lnk.txd    = s_q.txd;
  assign o_tx_ready = s_q.rdy;
  assign o_rx_valid = s_q.rv;
  assign o_rx_data  = s_q.rd;
  assign o_rx_err   = s_q.re;
  assign o_col      = s_q.col;
endmodule

// [rtl/pmd_phy.sv]
/*
  pmd_phy: transceiver end of the MAC data interface in nibble, reduced
  and serial forms. Line side is a plain user port: received units with
  valid, error and carrier; transmitted units come out with their enable.
  Assumes tx_en and txd from the MAC are launched on the clock it sees.
*/
// Functional notes
// - nibble tx clock 25 or 2.5 MHz
// - reduced form times both on reference
// - serial tx clock 10 MHz for MAC
// - MAC enable high exactly with valid data
// - reduced tx sampled on reference, nibble on tx clock
// - nibble rx clock 25 or 2.5 MHz
// - serial rx clock 10 MHz
// - nibble rx data valid only when valid
// - reduced data valid independent of carrier
// - nibble rx error on bad symbol
// - reduced rx error on media error
// - corrupt delivered data on receive error
// - reduced two rx bits on reference
// - serial uses rx bit 0 only
// - carrier high while medium non-idle
// - reduced combined carrier and data valid
// - collision on simultaneous tx and rx
// - heartbeat pulse about 1 us after transmit
// - full duplex holds collision low
// - reduced MAC derives collision itself
// - default nibble form via strap pulldown
`timescale 1ns/1ps
module pmd_phy
  import pmd_pkg::*;
#(
  parameter int unsigned SQE_LEN = SQE_CYCLES
) (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // configuration
  input  wire logic       i_strap_red,
  input  wire logic       i_strap_serial,
  input  wire logic       i_fast,
  input  wire logic       i_full_duplex,
  input  wire logic       i_heartbeat_en,
  // line side receive
  input  wire logic [3:0] i_line_rxd,
  input  wire logic       i_line_rx_valid,
  input  wire logic       i_line_rx_err,
  input  wire logic       i_line_carrier,
  // line side transmit and form
  output logic [3:0]      o_line_txd,
  output logic            o_line_tx_valid,
  output logic [1:0]      o_form,
  // link
  pmd_if.phy              lnk
);
  typedef enum logic [2:0] {
    ST_STRAP = 3'h1,
    ST_RUN   = 3'h2,
    ST_HOLD  = 3'h4
  } pmd_st_e;

  typedef struct packed {
    pmd_st_e      st;
    logic [1:0]   form;
    logic [3:0]   ltxd;
    logic         ltxv;
    logic         txen_prev;
    logic [SQE_W-1:0] sqe;
    logic [3:0]   rxd;
    logic         rx_dv;
    logic         rx_er;
    logic         crs;
    logic         col;
    logic         link_clk;
    logic         ref_clk;
    logic         col_pin;
  } pmd_phy_s;

  pmd_phy_s s_q;
  pmd_phy_s s_d;

  logic             tclk;
  logic             trise;
  logic [DIV_W-1:0] half;

  always_comb begin
    half = DIV_W'(HALF_NIB_FAST);
    if (s_q.form == FORM_SERIAL) begin
      half = DIV_W'(HALF_SERIAL);
    end else if (s_q.form == FORM_RED) begin
      half = DIV_W'(HALF_RED);
    end else if (!i_fast) begin
      half = DIV_W'(HALF_NIB_SLOW);
    end
  end

  pmd_clkdiv #(.W(DIV_W)) u_div (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_half (half),
    .o_clk  (tclk),
    .o_rise (trise)
  );

  always_comb begin
    s_d      = s_q;
    s_d.ltxv = 1'b0;
    case (s_q.st)
      ST_STRAP: begin
        s_d.form = i_strap_serial ? FORM_SERIAL : (i_strap_red ? FORM_RED : FORM_NIB);
        s_d.st   = ST_RUN;
      end
      ST_RUN, ST_HOLD: begin
        s_d.st = ST_RUN;
        // heartbeat countdown; a new start below wins
        if (s_q.sqe != '0) begin
          s_d.sqe = SQE_W'(s_q.sqe - 1'b1);
          s_d.st  = ST_HOLD;
        end
        if (trise) begin
          // sample transmit side on link clock edge
          s_d.txen_prev = lnk.tx_en;
          s_d.ltxv      = lnk.tx_en;
          case (s_q.form)
            FORM_RED:    s_d.ltxd = {2'h0, lnk.txd[1:0]};
            FORM_SERIAL: s_d.ltxd = {3'h0, lnk.txd[0]};
            default:     s_d.ltxd = lnk.txd;
          endcase
          s_d.rxd = i_line_rx_err ? ~i_line_rxd : i_line_rxd;
          s_d.crs = i_line_carrier;
          case (s_q.form)
            FORM_RED: begin
              s_d.rxd   = {2'h0, s_d.rxd[1:0]};
              s_d.rx_dv = i_line_rx_valid;
              // media error while valid at 100
              s_d.rx_er = i_fast & i_line_rx_err & i_line_rx_valid;
              s_d.crs   = i_line_carrier | i_line_rx_valid;
              // no collision pin in reduced form
              s_d.col   = 1'b0;
            end
            FORM_SERIAL: begin
              // bit 0 only, no valid or error
              s_d.rxd   = {3'h0, s_d.rxd[0]};
              s_d.rx_dv = 1'b0;
              s_d.rx_er = 1'b0;
            end
            default: begin
              s_d.rx_dv = i_line_rx_valid;
              // bad symbol inside packet at 100
              s_d.rx_er = i_fast & i_line_rx_err & i_line_rx_valid;
            end
          endcase
          if (s_q.form != FORM_RED) begin
            s_d.col = ~i_full_duplex & lnk.tx_en & i_line_carrier;
          end
          // heartbeat after transmit end at 10
          if (s_q.txen_prev && !lnk.tx_en && !i_fast && i_heartbeat_en && !i_full_duplex &&
              s_q.form == FORM_NIB) begin
            s_d.sqe = SQE_W'(SQE_LEN);
          end
        end
        if (i_full_duplex) begin
          s_d.sqe = '0;
          s_d.col = 1'b0;
        end
      end
      default: s_d.st = ST_STRAP;
    endcase
    // reduced form quiets tx and rx clocks
    // unused pins of other forms held low
    s_d.link_clk = (s_d.form != FORM_RED) & tclk;
    // rx clock mirrors tx clock rate
    // serial rx clock at 10 MHz
    s_d.ref_clk  = (s_d.form == FORM_RED) & tclk;
    s_d.col_pin  = s_d.col | (s_d.sqe != '0);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q      <= '0;
      s_q.st   <= ST_STRAP;
      s_q.form <= FORM_NIB;
    end else begin
      s_q <= s_d;
    end
  end

  // serial tx clock driven to MAC
  assign lnk.tx_clk  = s_q.link_clk;
  assign lnk.rx_clk  = s_q.link_clk;
  assign lnk.ref_clk = s_q.ref_clk;
  assign lnk.crs    = s_q.crs;
  assign lnk.rxd    = s_q.rxd;
  assign lnk.rx_dv  = s_q.rx_dv;
  assign lnk.rx_er  = s_q.rx_er;
  assign lnk.col    = s_q.col_pin;
  assign o_line_txd      = s_q.ltxd;
  assign o_line_tx_valid = s_q.ltxv;
  assign o_form          = s_q.form;
endmodule

// [rtl/pmd_pkg.sv]
/*
  pmd_pkg: constants shared by the transceiver end and the MAC end of
  the MAC data interface.
  Assumes a single 100 MHz system clock on both ends.
*/
package pmd_pkg;
  // interface forms, selected by the strap at reset
  localparam logic [1:0] FORM_NIB    = 2'h0;
  localparam logic [1:0] FORM_RED    = 2'h1;
  localparam logic [1:0] FORM_SERIAL = 2'h2;

  // system clock
  localparam int unsigned CLK_MHZ = 100;

  // link clock rates in kHz
  localparam int unsigned NIB_FAST_KHZ  = 25000;
  localparam int unsigned NIB_SLOW_KHZ  = 2500;
  localparam int unsigned SERIAL_KHZ    = 10000;
  localparam int unsigned REF_RED_KHZ   = 50000;

  // half periods in system cycles
  localparam int unsigned HALF_NIB_FAST = (CLK_MHZ * 1000) / (2 * NIB_FAST_KHZ);
  localparam int unsigned HALF_NIB_SLOW = (CLK_MHZ * 1000) / (2 * NIB_SLOW_KHZ);
  localparam int unsigned HALF_SERIAL   = (CLK_MHZ * 1000) / (2 * SERIAL_KHZ);
  localparam int unsigned HALF_RED      = (CLK_MHZ * 1000) / (2 * REF_RED_KHZ);

  // heartbeat pulse, printed as 1 us
  localparam int unsigned SQE_NS     = 1000;
  localparam int unsigned SQE_CYCLES = (SQE_NS * CLK_MHZ + 999) / 1000;

  localparam int unsigned DIV_W = 8;
  localparam int unsigned SQE_W = 8;
endpackage

// [testbench/phy_mac_data_interface_bench.sv]
/*
  phy_mac_data_interface_bench: both ends joined, user sides compared.
  Assumes 100 MHz clock and a heartbeat shortened to 5 cycles.
*/
`timescale 1ns/1ps
module phy_mac_data_interface_bench;
  import pmd_pkg::*;
  logic       i_clk, i_rst, i_strap_red, i_strap_serial, i_fast, i_full_duplex, i_heartbeat_en;
  logic       i_line_rx_valid, i_line_rx_err, i_line_carrier, o_line_tx_valid, i_tx_valid, o_tx_ready;
  logic       o_rx_valid, o_rx_err, o_col, chk_rx;
  logic [3:0] i_line_rxd, o_line_txd, i_tx_data, o_rx_data, exp_rx;
  logic [1:0] o_form;
  logic [3:0] q[$];
  int         n_mismatch, n_tests, n_col, n_ocol;

  pmd_if lnk();
  pmd_phy #(.SQE_LEN(5)) pmd_phy_i(.i_clk, .i_rst, .i_strap_red, .i_strap_serial, .i_fast, .i_full_duplex,
    .i_heartbeat_en, .i_line_rxd, .i_line_rx_valid, .i_line_rx_err, .i_line_carrier, .o_line_txd,
    .o_line_tx_valid, .o_form, .lnk(lnk));
  pmd_mac pmd_mac_i(.i_clk, .i_rst, .i_form(o_form), .i_tx_valid, .i_tx_data, .o_tx_ready, .o_rx_valid,
    .o_rx_data, .o_rx_err, .o_col, .lnk(lnk));
  pmd_properties pmd_properties_i(.i_clk, .i_rst, .o_form, .tx_clk(lnk.tx_clk), .rx_clk(lnk.rx_clk),
    .ref_clk(lnk.ref_clk), .rxd(lnk.rxd), .rx_dv(lnk.rx_dv), .rx_er(lnk.rx_er), .crs(lnk.crs), .col(lnk.col));

  always #5 i_clk = ~i_clk;

  task automatic cmp(string n, logic [3:0] e, logic [3:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task summarize;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge i_clk) if (!i_rst) begin
    if (o_line_tx_valid) cmp("txd", q.size() ? q.pop_front() : 4'hx, o_line_txd);
    if (o_rx_valid && chk_rx) cmp("rxd", exp_rx, o_rx_data);
    n_col += int'(lnk.col);
    n_ocol += int'(o_col);
  end

  // hold the unit until the MAC takes it
  task automatic send(logic [3:0] d, logic [3:0] m);
    int k;
    k = 0;
    i_tx_valid = 1;
    i_tx_data = d;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_tx_ready !== 1'b1 && k < 300);
    if (k == 300) cmp("tx ready", 4'h1, {3'h0, o_tx_ready});
    q.push_back(d & m);
    #1;
  endtask

  task automatic run(logic r, logic s, logic f, logic d, logic h, string nm);
    logic [3:0] m, v;
    logic [1:0] ef;
    m = s ? 4'h1 : r ? 4'h3 : 4'hf;
    ef = s ? 2'h2 : r ? 2'h1 : 2'h0;
    i_rst = 1;
    {i_strap_red, i_strap_serial, i_fast, i_full_duplex, i_heartbeat_en} = {r, s, f, d, h};
    repeat (3) @(posedge i_clk);
    #1 i_rst = 0;
    repeat (3) @(posedge i_clk);
    #1 cmp("form", {2'h0, ef}, {2'h0, o_form});
    v = 4'($urandom);
    {i_line_rxd, i_line_rx_valid, i_line_carrier} = {v, 2'b11};
    repeat (100) @(posedge i_clk);
    #1 exp_rx = v & m;
    chk_rx = 1;
    if (r) begin
      cmp("reduced rxd", v & m, lnk.rxd);
      cmp("reduced crs", 4'h1, {3'h0, lnk.crs});
    end
    repeat (200) @(posedge i_clk);
    #1 chk_rx = 0;
    if (ef == 2'h0 && f) begin
      i_line_rx_err = 1;
      repeat (100) @(posedge i_clk);
      #1 exp_rx = ~v;
      chk_rx = 1;
      cmp("rx_er", 4'h1, {3'h0, lnk.rx_er});
      cmp("o_rx_err", 4'h1, {3'h0, o_rx_err});
      repeat (100) @(posedge i_clk);
      #1 {chk_rx, i_line_rx_err} = 2'b00;
    end
    i_line_rx_valid = 0;
    i_line_carrier = !h;
    repeat (100) @(posedge i_clk);
    #1 n_col = 0;
    n_ocol = 0;
    repeat (6) send(4'($urandom), m);
    i_tx_valid = 0;
    i_line_carrier = 0;
    repeat (400) @(posedge i_clk);
    #1 cmp("drain", 4'h0, 4'(q.size()));
    cmp("col", (d || r) ? 4'h0 : h ? 4'h5 : 4'h1, h ? 4'(n_col) : {3'h0, n_col > 0});
    if (!h) cmp("mac col", {3'h0, !d}, {3'h0, n_ocol > 0});
    $display("done %s", nm);
  endtask

  initial begin
    i_clk = 0;
    i_rst = 1;
    {i_strap_red, i_strap_serial, i_fast, i_full_duplex, i_heartbeat_en, i_line_rxd, i_line_rx_valid,
      i_line_rx_err, i_line_carrier, i_tx_valid, i_tx_data, chk_rx, exp_rx} = '0;
    void'($urandom(85698));
    #1;
    run(0, 0, 1, 0, 0, "nibble fast");
    run(0, 0, 0, 0, 1, "nibble slow heartbeat");
    run(0, 1, 0, 0, 0, "serial");
    run(1, 0, 1, 0, 0, "reduced");
    run(0, 0, 1, 1, 0, "nibble full duplex");
    summarize();
  end

  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end
endmodule

// [testbench/pmd_properties.sv]
/*
  pmd_properties: timing and quiet-pin checks on the link wires.
  Assumes one clock, i_rst async high, phy form output visible.
*/
`timescale 1ns/1ps
module pmd_properties (
  // clock, reset, form
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [1:0] o_form,
  // link wires
  input  wire logic       tx_clk,
  input  wire logic       rx_clk,
  input  wire logic       ref_clk,
  input  wire logic [3:0] rxd,
  input  wire logic       rx_dv,
  input  wire logic       rx_er,
  input  wire logic       crs,
  input  wire logic       col
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // serial clock high five cycles, then low
  sequence s_half5;
    tx_clk [*5] ##1 !tx_clk;
  endsequence

  property p_red_clk; o_form == 2'h1 |-> !tx_clk && !rx_clk; endproperty
  a_red_clk: assert property (p_red_clk) else $error("link clock runs in reduced form");
  property p_ser_quiet; o_form == 2'h2 |-> rxd[3:1] == 3'h0 && !rx_dv && !rx_er; endproperty
  a_ser_quiet: assert property (p_ser_quiet) else $error("serial unused pins active");
  property p_red_rxd; o_form == 2'h1 |-> rxd[3:2] == 2'h0; endproperty
  a_red_rxd: assert property (p_red_rxd) else $error("reduced upper rx bits set");
  property p_red_col; o_form == 2'h1 |-> !col; endproperty
  a_red_col: assert property (p_red_col) else $error("collision in reduced form");
  property p_ref_quiet; o_form != 2'h1 |-> !ref_clk; endproperty
  a_ref_quiet: assert property (p_ref_quiet) else $error("reference runs outside reduced");
  property p_rx_clk; $rose(rx_clk) |-> (rx_clk && tx_clk) [*2]; endproperty
  a_rx_clk: assert property (p_rx_clk) else $error("rx clock differs from tx clock");
  property p_ser_rate; o_form == 2'h2 && $rose(tx_clk) |-> s_half5; endproperty
  a_ser_rate: assert property (p_ser_rate) else $error("serial clock half period wrong");
  property p_red_crs; o_form == 2'h1 && rx_dv |-> crs; endproperty
  a_red_crs: assert property (p_red_crs) else $error("combined carrier low while valid");
  property p_er_dv; rx_er |-> rx_dv; endproperty
  a_er_dv: assert property (p_er_dv) else $error("rx error without valid");
endmodule
